//--- bench/dag_ram_model.sv
/*
  Behavioural data RAM facing the address generator.
  Assumes registered mem_s strobes from the generator and one core clock.
*/
`timescale 1ns/1ps
module dag_ram_model (
  input wire logic pclk,
  input wire dag_pkg::mem_s mem_i,
  output logic [7:0] rdata
);
  logic [7:0] store [0:4095];
  logic [7:0] last_r;

  // Outside a read the port shows the inverse of the last word, so a late sample is caught.
  assign rdata = mem_i.rd ? store[mem_i.addr] : ~last_r;

  initial begin
    for (int i = 0; i < 4096; i++) begin
      store[i] = 8'(i) ^ 8'ha5;
    end
    last_r = 8'h00;
  end

  always @(posedge pclk) begin
    if (mem_i.wr) begin
      store[mem_i.addr] <= mem_i.wdata;
    end
    if (mem_i.rd) begin
      last_r <= store[mem_i.addr];
    end
  end
endmodule : dag_ram_model

//--- bench/data_address_generator_tb_top.sv
/*
  Self-checking bench for the data address generator.
  Assumes dag_ram_model on the memory side and one 20 MHz clock.
*/
`timescale 1ns/1ps
module data_address_generator_tb_top;
  logic pclk, presetn, cen, req_valid, wb_valid, psel, penable, pwrite;
  logic rvalid_r, busy, pready, pslverr;
  logic [7:0] w_val, wb_data, ram_rdata, rdata_r, paddr;
  logic [31:0] pwdata, prdata;
  dag_pkg::req_s req;
  dag_pkg::mem_s mem_r;
  dag_pkg::resp_s resp_r;
  int err_total, tests_run, seed;
  logic [13:0] mem_q[$];
  logic [7:0] rd_q[$];
  logic [32:0] resp_q[$];
  logic [33:0] apb_q[$];
  logic [32:0] n;
  logic [33:0] a;

  data_address_generator dut_u (.pclk(pclk), .presetn(presetn), .cen(cen),
    .req_valid(req_valid), .req(req), .w_val(w_val), .wb_valid(wb_valid), .wb_data(wb_data),
    .mem_r(mem_r), .ram_rdata(ram_rdata), .resp_r(resp_r), .rvalid_r(rvalid_r),
    .rdata_r(rdata_r), .busy(busy), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dag_ram_model ram_u (.pclk(pclk), .mem_i(mem_r), .rdata(ram_rdata));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // An empty queue yields unknown, so an unexpected strobe always mismatches.
  always @(posedge pclk) begin
    if (mem_r.rd || mem_r.wr) begin
      check("mem", mem_q.size() > 0 ? 33'(mem_q.pop_front()) : 33'bx,
            {19'h0, mem_r.rd, mem_r.wr, mem_r.addr});
    end
    if (rvalid_r) begin
      check("rdata", rd_q.size() > 0 ? 33'(rd_q.pop_front()) : 33'bx, 33'(rdata_r));
    end
    if (resp_r.valid) begin
      n = resp_q.size() > 0 ? resp_q.pop_front() : 33'bx;
      if (n[32] === 1'b1) begin
        check("dest", n, {1'b1, resp_r.to_file, resp_r.to_work, 30'h0});
      end else begin
        check("literal", n, {3'b0, resp_r.jump, resp_r.imm, resp_r.jump ? resp_r.target : 20'h0,
              resp_r.imm ? resp_r.imm_val : 8'h00});
      end
    end
    if (psel && penable && pready && !pwrite) begin
      a = apb_q.size() > 0 ? apb_q.pop_front() : 34'bx;
      if (a[33] === 1'b1) begin
        check("pslverr", 33'h1, 33'(pslverr));
      end else begin
        check("prdata", a[32:0], {pslverr, prdata});
      end
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] ad, input logic [33:0] x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= x[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) apb_q.push_back(x);
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Leaves req_valid high so that calls run back to back; idle drops it.
  task automatic op(input logic full, input logic [7:0] f, input logic ab, input logic rd,
                    input logic wr, input logic [7:0] w, input logic to_mem,
                    input logic [11:0] ea, input logic [7:0] ed);
    dag_pkg::req_s r;
    r = '0;
    r.mode = full ? dag_pkg::MODE_FULL : dag_pkg::MODE_DIRECT;
    r.f = f;
    r.abit = ab;
    r.full_addr = ea;
    r.rd = rd;
    r.wr = wr;
    r.wdata = 8'h66;
    r.has_d = rd;
    r.dbit = wr;
    r.impl_file = !rd;
    req <= r;
    w_val <= w;
    req_valid <= 1'b1;
    resp_q.push_back({1'b1, !rd | wr, rd & !wr, 30'h0});
    if (to_mem) mem_q.push_back({rd, wr & !rd, ea});
    if (to_mem && rd && wr) mem_q.push_back({2'b01, ea});
    if (rd) rd_q.push_back(ed);
    do @(posedge pclk); while (busy !== 1'b0);
  endtask : op

  task automatic lit(input dag_pkg::mode_e m, input logic j, input logic [19:0] l);
    logic imm;
    imm = (m == dag_pkg::MODE_LITERAL) && !j;
    req <= '{mode: m, is_jump: j, lit: l, default: '0};
    req_valid <= 1'b1;
    resp_q.push_back({3'b0, j, imm, j ? l : 20'h0, imm ? l[7:0] : 8'h00});
    @(posedge pclk);
  endtask : lit

  task automatic idle();
    req_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : idle

  task automatic conclude();
    if (mem_q.size() + rd_q.size() + resp_q.size() + apb_q.size() != 0) begin
      err_total++;
      $display("[ERR] leftover expected 0 seen %0d",
               mem_q.size() + rd_q.size() + resp_q.size() + apb_q.size());
    end
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (4000) @(posedge pclk);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] b;
    logic [7:0] f;
    seed = 15;
    err_total = 0;
    tests_run = 0;
    {presetn, req_valid, wb_valid, psel, penable, pwrite} = '0;
    cen = 1'b1;
    req = '0;
    {w_val, wb_data, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, dag_pkg::OFF_PTR0, 34'(dag_pkg::PTR_RST));
    apb(0, 8'h14, 34'h200000000);
    apb(1, dag_pkg::OFF_BANK_SEL, 34'h5);
    op(0, 8'h34, 1, 1, 0, 0, 1, 12'h534, 8'h91);
    op(0, 8'h5f, 0, 1, 0, 0, 1, 12'h05f, 8'hfa);
    op(0, 8'h60, 0, 1, 0, 0, 1, 12'hf60, 8'hc5);
    op(1, 8'h00, 1, 1, 0, 0, 1, 12'habc, 8'h19);
    op(0, 8'h10, 1, 0, 1, 0, 1, 12'h510, 8'h00);
    lit(dag_pkg::MODE_LITERAL, 1, 20'habcde);
    lit(dag_pkg::MODE_LITERAL, 0, 20'h00012);
    lit(dag_pkg::MODE_INHERENT, 0, 20'h00000);
    idle();
    apb(1, dag_pkg::OFF_PTR0, 34'h0ff);
    op(0, 8'he1, 0, 1, 0, 0, 1, 12'h0ff, 8'h5a);
    op(0, 8'he2, 0, 1, 0, 0, 1, 12'h100, 8'ha5);
    op(0, 8'he3, 0, 1, 0, 0, 1, 12'h100, 8'ha5);
    op(0, 8'he4, 0, 1, 0, 8'h80, 1, 12'h080, 8'h25);
    op(0, 8'he4, 0, 1, 0, 8'h7f, 1, 12'h17f, 8'hda);
    idle();
    apb(1, dag_pkg::OFF_BANK_SEL, 34'hf);
    op(0, 8'he0, 1, 1, 0, 0, 1, 12'h100, 8'ha5);
    idle();
    apb(0, dag_pkg::OFF_PTR0, 34'h100);
    apb(0, dag_pkg::OFF_LAST, 34'h100);
    apb(1, dag_pkg::OFF_PTR1, 34'hfe0);
    op(0, 8'he8, 0, 1, 0, 0, 0, 12'h000, 8'h00);
    op(0, 8'he9, 0, 0, 1, 0, 0, 12'h000, 8'h00);
    idle();
    apb(0, dag_pkg::OFF_PTR1, 34'hfe1);
    apb(1, dag_pkg::OFF_PTR2, 34'hff5);
    op(0, 8'hf1, 0, 0, 1, 0, 0, 12'h000, 8'h00);
    op(0, 8'hed, 0, 0, 1, 0, 0, 12'h000, 8'h00);
    op(0, 8'hee, 0, 0, 1, 0, 0, 12'h000, 8'h00);
    idle();
    apb(0, dag_pkg::OFF_PTR2, 34'hf66);
    apb(0, dag_pkg::OFF_PTR1, 34'h666);
    for (int i = 0; i < 8; i++) begin
      b = 4'(6 + $unsigned($random(seed)) % 9);
      f = 8'($random(seed));
      apb(1, dag_pkg::OFF_BANK_SEL, 34'(b));
      op(0, f, 1, 1, 0, 0, 1, {b, f}, f ^ 8'ha5);
      idle();
    end
    op(0, 8'he1, 0, 1, 1, 0, 1, 12'h100, 8'ha5);
    idle();
    wb_valid <= 1'b1;
    wb_data <= 8'h3c;
    @(posedge pclk);
    wb_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(0, dag_pkg::OFF_PTR0, 34'h101);
    // A request held while the clock enable is low must be taken exactly once.
    cen <= 1'b0;
    op(0, 8'he1, 0, 1, 0, 0, 1, 12'h101, 8'ha4);
    repeat (2) @(posedge pclk);
    cen <= 1'b1;
    @(posedge pclk);
    idle();
    apb(0, dag_pkg::OFF_PTR0, 34'h102);
    op(0, 8'hf8, 0, 0, 1, 0, 0, 12'h000, 8'h00);
    op(0, 8'hf8, 0, 1, 0, 0, 0, 12'h000, 8'h06);
    op(0, 8'he5, 0, 1, 0, 0, 0, 12'h000, 8'h02);
    idle();
    apb(0, dag_pkg::OFF_BANK_SEL, 34'h6);
    repeat (3) @(posedge pclk);
    conclude();
  end
endmodule : data_address_generator_tb_top

//--- src/dag_pkg.sv
/*
  Constants, encodings and carrier types for the data address generator.
  Assumes one core clock and a decoder that presents one request at a time.
*/
package dag_pkg;

  localparam int PTR_W = 12;
  localparam int NUM_PAIRS = 3;

  // ----------------------------------------------------------------
  // Register region at the top of bank 15
  // ----------------------------------------------------------------
  localparam logic [6:0] SFR_REGION = 7'h7f;
  localparam logic [1:0] BANK_SEL_SLOT = 2'h3;
  localparam logic [2:0] K_PLAIN = 3'h0;
  localparam logic [2:0] K_POST_INC = 3'h1;
  localparam logic [2:0] K_POST_DEC = 3'h2;
  localparam logic [2:0] K_PRE_INC = 3'h3;
  localparam logic [2:0] K_OFFSET = 3'h4;
  localparam logic [2:0] K_LOW = 3'h5;
  localparam logic [2:0] K_HIGH = 3'h6;
  localparam logic [2:0] K_BANK_SEL = 3'h0;

  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [7:0] NESTED_READ_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Bus offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_BANK_SEL = 8'h00;
  localparam logic [7:0] OFF_PTR0 = 8'h04;
  localparam logic [7:0] OFF_PTR1 = 8'h08;
  localparam logic [7:0] OFF_PTR2 = 8'h0c;
  localparam logic [7:0] OFF_LAST = 8'h10;
  localparam logic [3:0] BANK_SEL_RST = 4'h0;
  localparam logic [11:0] PTR_RST = 12'h000;

  typedef enum logic [1:0] {
    MODE_INHERENT = 2'b00,
    MODE_LITERAL = 2'b01,
    MODE_DIRECT = 2'b11,
    MODE_FULL = 2'b10
  } mode_e;

  typedef struct packed {
    mode_e mode;
    logic [7:0] f;
    logic abit;
    logic has_d;
    logic dbit;
    logic impl_file;
    logic [11:0] full_addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic is_jump;
    logic [19:0] lit;
  } req_s;

  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mem_s;

  typedef struct packed {
    logic valid;
    logic to_file;
    logic to_work;
    logic jump;
    logic [19:0] target;
    logic imm;
    logic [7:0] imm_val;
  } resp_s;

endpackage : dag_pkg

//--- src/data_address_generator.sv
/*
  Operand address generator: direct, full and pointer-based addressing,
  destination select and literal routing, with an APB register port.
  Assumes an asynchronous data RAM that answers within the cycle and a
  decoder that waits for the read data before finishing a read-modify-write.
*/
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module data_address_generator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  input wire logic req_valid,
  input wire dag_pkg::req_s req,
  input wire logic [7:0] w_val,
  input wire logic wb_valid,
  input wire logic [7:0] wb_data,
  output dag_pkg::mem_s mem_r,
  input wire logic [7:0] ram_rdata,
  output dag_pkg::resp_s resp_r,
  output logic rvalid_r,
  output logic [7:0] rdata_r,
  output logic busy,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Address classification
  // ----------------------------------------------------------------
  function automatic logic in_region(input logic [11:0] a);
    return a[11:5] == dag_pkg::SFR_REGION;
  endfunction : in_region

  function automatic logic is_virt(input logic [11:0] a);
    return in_region(a) && a[4:3] != dag_pkg::BANK_SEL_SLOT && a[2:0] <= dag_pkg::K_OFFSET;
  endfunction : is_virt

  function automatic logic is_ptr_byte(input logic [11:0] a);
    return in_region(a) && a[4:3] != dag_pkg::BANK_SEL_SLOT &&
           (a[2:0] == dag_pkg::K_LOW || a[2:0] == dag_pkg::K_HIGH);
  endfunction : is_ptr_byte

  function automatic logic is_bank_sel(input logic [11:0] a);
    return in_region(a) && a[4:3] == dag_pkg::BANK_SEL_SLOT && a[2:0] == dag_pkg::K_BANK_SEL;
  endfunction : is_bank_sel

  logic [3:0] bank_sel_r;
  logic [2:0][11:0] ptrs;
  logic [11:0] last_ea_r;
  logic pend_r;
  logic [11:0] pend_ea_r;
  logic pend_nested_r;
  logic pend_inc_r;
  logic pend_dec_r;
  logic [1:0] pend_idx_r;
  logic [1:0] rsel_r;
  logic [7:0] sfr_val_r;

  logic take;
  logic mem_op;
  logic rmw;
  logic [11:0] da;
  logic [1:0] slot;
  logic [2:0] kind;
  logic da_virt;
  logic [11:0] base;
  logic [11:0] ea;
  logic nested;
  logic cur_inc;
  logic cur_dec;
  logic fin_cur;
  logic commit;
  logic wp_act;
  logic [11:0] wp_ea;
  logic wp_nested;
  logic [7:0] wp_data;
  logic st_act;
  logic st_inc;
  logic st_dec;
  logic [1:0] st_idx;
  logic [2:0] we_lo;
  logic [2:0] we_hi;
  logic [2:0] we_all;
  logic [2:0] step_inc;
  logic [2:0] step_dec;
  logic own_written;
  logic apb_wr;
  logic [7:0] sfr_val;

  assign take = req_valid && cen && !pend_r;
  assign rmw = req.rd && req.wr;
  assign mem_op = take && (req.mode == dag_pkg::MODE_DIRECT || req.mode == dag_pkg::MODE_FULL) &&
                  (req.rd || req.wr);

  // ----------------------------------------------------------------
  // Direct address
  // ----------------------------------------------------------------
  always_comb begin
    unique case (req.mode)
      dag_pkg::MODE_DIRECT: begin
        if (req.abit) begin
          da = {bank_sel_r, req.f};
        end else if (req.f < dag_pkg::ACCESS_SPLIT) begin
          da = {dag_pkg::ACCESS_LO_BANK, req.f};
        end else begin
          da = {dag_pkg::ACCESS_HI_BANK, req.f};
        end
      end
      dag_pkg::MODE_FULL: da = req.full_addr;
      dag_pkg::MODE_INHERENT, dag_pkg::MODE_LITERAL: da = 12'h000;
    endcase
  end

  assign slot = da[4:3];
  assign kind = da[2:0];
  assign da_virt = is_virt(da);
  assign base = (slot == dag_pkg::BANK_SEL_SLOT) ? 12'h000 : ptrs[slot];

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  // Bank select and access bit never reach a pointer address.
  always_comb begin
    ea = da;
    if (da_virt) begin
      unique case (kind)
        dag_pkg::K_PRE_INC: ea = base + 12'h001;
        dag_pkg::K_OFFSET: ea = base + {{4{w_val[7]}}, w_val};
        default: ea = base;
      endcase
    end
  end

  assign nested = da_virt && is_virt(ea);
  assign cur_inc = da_virt && (kind == dag_pkg::K_POST_INC || kind == dag_pkg::K_PRE_INC);
  assign cur_dec = da_virt && kind == dag_pkg::K_POST_DEC;

  // A lone read or write finishes at once; a read-modify-write finishes at
  // the commit so that both halves use one address and one step.
  assign fin_cur = mem_op && !rmw;
  assign commit = wb_valid && cen && pend_r;
  assign wp_act = (fin_cur && req.wr) || commit;
  assign wp_ea = commit ? pend_ea_r : ea;
  assign wp_nested = commit ? pend_nested_r : nested;
  assign wp_data = commit ? wb_data : req.wdata;
  assign st_act = fin_cur || commit;
  assign st_inc = commit ? pend_inc_r : cur_inc;
  assign st_dec = commit ? pend_dec_r : cur_dec;
  assign st_idx = commit ? pend_idx_r : slot;
  assign busy = pend_r;

  // ----------------------------------------------------------------
  // Pointer pairs
  // ----------------------------------------------------------------
  assign own_written = we_lo[st_idx] || we_hi[st_idx];

  for (genvar i = 0; i < dag_pkg::NUM_PAIRS; i++) begin : g_pair
    assign we_lo[i] = wp_act && !wp_nested && is_ptr_byte(wp_ea) &&
                      wp_ea[4:3] == 2'(i) && wp_ea[2:0] == dag_pkg::K_LOW;
    assign we_hi[i] = wp_act && !wp_nested && is_ptr_byte(wp_ea) &&
                      wp_ea[4:3] == 2'(i) && wp_ea[2:0] == dag_pkg::K_HIGH;
    assign step_inc[i] = st_act && st_inc && st_idx == 2'(i) && !own_written;
    assign step_dec[i] = st_act && st_dec && st_idx == 2'(i) && !own_written;
    assign we_all[i] = apb_wr && paddr == dag_pkg::OFF_PTR0 + 8'(4 * i);

    pointer_pair #(
      .PW(dag_pkg::PTR_W)
    ) u_pair (
      .pclk(pclk),
      .presetn(presetn),
      .cen(cen),
      .we_lo(we_lo[i]),
      .we_hi(we_hi[i]),
      .we_all(we_all[i]),
      .wdata(wp_data),
      .wall(pwdata[11:0]),
      .inc(step_inc[i]),
      .dec(step_dec[i]),
      .ptr(ptrs[i])
    );
  end

  // ----------------------------------------------------------------
  // Bank select and observed address
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_sel_r <= dag_pkg::BANK_SEL_RST;
    end else if (cen) begin
      if (wp_act && !wp_nested && is_bank_sel(wp_ea)) begin
        bank_sel_r <= wp_data[3:0];
      end else if (apb_wr && paddr == dag_pkg::OFF_BANK_SEL) begin
        bank_sel_r <= pwdata[3:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ea_r <= 12'h000;
    end else if (mem_op) begin
      last_ea_r <= ea;
    end
  end

  // ----------------------------------------------------------------
  // Pending read-modify-write
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
      pend_ea_r <= 12'h000;
      pend_nested_r <= 1'b0;
      pend_inc_r <= 1'b0;
      pend_dec_r <= 1'b0;
      pend_idx_r <= 2'h0;
    end else if (commit) begin
      pend_r <= 1'b0;
    end else if (mem_op && rmw) begin
      pend_r <= 1'b1;
      pend_ea_r <= ea;
      pend_nested_r <= nested;
      pend_inc_r <= cur_inc;
      pend_dec_r <= cur_dec;
      pend_idx_r <= slot;
    end
  end

  // ----------------------------------------------------------------
  // Data RAM strobes
  // ----------------------------------------------------------------
  always_comb begin
    sfr_val = {4'h0, bank_sel_r};
    if (is_ptr_byte(ea)) begin
      sfr_val = (ea[2:0] == dag_pkg::K_LOW) ? ptrs[ea[4:3]][7:0] : {4'h0, ptrs[ea[4:3]][11:8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_r <= '0;
    end else if (cen) begin
      mem_r.addr <= commit ? pend_ea_r : ea;
      mem_r.rd <= mem_op && req.rd && !nested && !is_ptr_byte(ea) && !is_bank_sel(ea);
      mem_r.wr <= wp_act && !wp_nested && !is_ptr_byte(wp_ea) && !is_bank_sel(wp_ea);
      mem_r.wdata <= wp_data;
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // Select codes: 0 idle, 1 RAM, 2 zero for a nested access, 3 register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsel_r <= 2'h0;
      sfr_val_r <= 8'h00;
    end else if (cen) begin
      rsel_r <= 2'h0;
      if (mem_op && req.rd) begin
        sfr_val_r <= sfr_val;
        if (nested) begin
          rsel_r <= 2'h2;
        end else if (is_ptr_byte(ea) || is_bank_sel(ea)) begin
          rsel_r <= 2'h3;
        end else begin
          rsel_r <= 2'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (cen) begin
      rvalid_r <= rsel_r != 2'h0;
      unique case (rsel_r)
        2'h1: rdata_r <= ram_rdata;
        2'h2: rdata_r <= dag_pkg::NESTED_READ_VALUE;
        2'h3: rdata_r <= sfr_val_r;
        2'h0: rdata_r <= rdata_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Destination and literal routing
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_r <= '0;
    end else if (cen) begin
      resp_r.valid <= take;
      resp_r.to_file <= take && (req.has_d ? req.dbit : req.impl_file);
      resp_r.to_work <= take && (req.has_d ? !req.dbit : !req.impl_file);
      resp_r.jump <= take && req.mode == dag_pkg::MODE_LITERAL && req.is_jump;
      resp_r.imm <= take && req.mode == dag_pkg::MODE_LITERAL && !req.is_jump;
      if (take && req.mode == dag_pkg::MODE_LITERAL) begin
        resp_r.target <= req.lit;
        resp_r.imm_val <= req.lit[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // The core has the register file first; the bus waits out its cycle.
  assign pready = cen && !st_act;
  assign apb_wr = psel && penable && pwrite && pready && !pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (cen && psel && !penable) begin
      pslverr <= 1'b0;
      unique case (paddr)
        dag_pkg::OFF_BANK_SEL: prdata <= {28'h000_0000, bank_sel_r};
        dag_pkg::OFF_PTR0: prdata <= {20'h0_0000, ptrs[0]};
        dag_pkg::OFF_PTR1: prdata <= {20'h0_0000, ptrs[1]};
        dag_pkg::OFF_PTR2: prdata <= {20'h0_0000, ptrs[2]};
        dag_pkg::OFF_LAST: prdata <= {19'h0_0000, pend_r, last_ea_r};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bank_join: assert property (@(posedge pclk) disable iff (!presetn)
    mem_op && req.mode == dag_pkg::MODE_DIRECT && req.abit && bank_sel_r != 4'hf |=>
      mem_r.addr == {$past(bank_sel_r), $past(req.f)})
    else $error("bank select not joined to field");

  a_access_split: assert property (@(posedge pclk) disable iff (!presetn)
    mem_op && req.mode == dag_pkg::MODE_DIRECT && !req.abit && !da_virt |=>
      mem_r.addr == {(($past(req.f) < 8'h60) ? 4'h0 : 4'hf), $past(req.f)})
    else $error("access bank mapped wrongly");

  a_full_direct: assert property (@(posedge pclk) disable iff (!presetn)
    mem_op && !rmw && req.mode == dag_pkg::MODE_FULL && !is_virt(req.full_addr) |=>
      mem_r.addr == $past(req.full_addr))
    else $error("full address not used");

  a_post_inc: assert property (@(posedge pclk) disable iff (!presetn)
    step_inc[0] && cen |=> ptrs[0] == $past(ptrs[0]) + 12'h001)
    else $error("pointer pair 0 not raised by one");

  a_post_dec: assert property (@(posedge pclk) disable iff (!presetn)
    step_dec[0] && cen |=> ptrs[0] == $past(ptrs[0]) - 12'h001)
    else $error("pointer pair 0 not lowered by one");

  a_offset_still: assert property (@(posedge pclk) disable iff (!presetn)
    fin_cur && da_virt && (kind == 3'h4 || kind == 3'h0) && !is_ptr_byte(ea) |=>
      $stable(ptrs))
    else $error("offset or plain access moved a pointer");

  a_nested_read: assert property (@(posedge pclk) disable iff (!presetn)
    mem_op && req.rd && nested ##1 cen |=> rvalid_r && rdata_r == 8'h00)
    else $error("nested read did not return zero");

  a_nested_write: assert property (@(posedge pclk) disable iff (!presetn)
    wp_act && wp_nested |=> !mem_r.wr && $stable(bank_sel_r))
    else $error("nested write had an effect");

  a_own_store: assert property (@(posedge pclk) disable iff (!presetn)
    we_lo[2] && cen && !we_all[2] |=> ptrs[2][7:0] == $past(wp_data))
    else $error("own pair write lost or stepped");

  a_single_step: assert property (@(posedge pclk) disable iff (!presetn)
    ((mem_op && rmw) || (pend_r && !commit)) && !(|we_all) |=> $stable(ptrs))
    else $error("pointer stepped before commit");

endmodule : data_address_generator

//--- src/pointer_pair.sv
/*
  One 12-bit pointer pair with byte loads, whole loads and unit steps.
  Assumes the caller never asks for a byte load and a step together.
*/
`timescale 1ns/1ps
module pointer_pair #(
  parameter int PW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic we_all,
  input wire logic [7:0] wdata,
  input wire logic [PW-1:0] wall,
  input wire logic inc,
  input wire logic dec,
  output logic [PW-1:0] ptr
);

  if (PW < 9 || PW > 16) begin : g_bad_width
    $error("pointer width must lie between 9 and 16");
  end

  // ----------------------------------------------------------------
  // Pointer storage
  // ----------------------------------------------------------------
  // The step acts on the whole pair so a low-byte roll-over carries
  // into the high byte; no flag output exists to be disturbed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= PW'(dag_pkg::PTR_RST);
    end else if (cen) begin
      if (we_all) begin
        ptr <= wall;
      end else if (we_lo) begin
        ptr[7:0] <= wdata;
      end else if (we_hi) begin
        ptr[PW-1:8] <= wdata[PW-9:0];
      end else if (inc) begin
        ptr <= ptr + PW'(1);
      end else if (dec) begin
        ptr <= ptr - PW'(1);
      end
    end
  end

endmodule : pointer_pair
